// ===== design/vdacr_top.sv
/*
  Digital front end of an 8-bit video converter: pixel FIFO, input register loaded
  on strobe, sync/blanking/peak-white overrides and current switch enables.
  Assumes the pixel source and the override lines are synchronous to pclk (40 MHz),
  and an APB master for configuration and status.
*/
// The address map and the APB slave port were decided locally.
`timescale 1ns/10ps
module vdacr_top #(
  parameter int unsigned CODE_W = vdacr_pkg::CODE_W,
  parameter int unsigned DEPTH  = vdacr_pkg::FIFO_DEPTH
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [CODE_W-1:0] pix_code,
  input  wire logic              pix_valid,
  output logic                   pix_ready,
  input  wire logic              strobe,
  input  wire logic              sync_n,
  input  wire logic              blank_n,
  input  wire logic              peak_n,
  output logic [CODE_W-1:0]      dac_code,
  output logic                   sw_sync_on,
  output logic                   sw_blank_on,
  output logic                   sw_setup_on,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr
);

  localparam int unsigned FW = $clog2(DEPTH) + 1;

  // refuse shapes that the register and fifo logic cannot serve
  initial begin
    if (CODE_W != 8) begin
      $error("input register width must be 8");
    end
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("fifo depth must be a power of two of at least 2");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  vdacr_stream_if #(.W(CODE_W)) pix_s ();

  logic                   fifo_in_ready;
  logic                   push;
  logic                   pop;
  logic                   flush;
  logic                   enable;
  logic [FW-1:0]          fill_q;
  logic [FW-1:0]          fill_d;
  logic                   pix_ready_q;
  logic                   pix_ready_d;
  logic                   strobe_q;
  logic                   strobe_rise;
  logic                   clearing;
  logic                   peak_on;
  logic                   conflict;
  logic                   load;
  logic [CODE_W-1:0]      code_q;
  logic [CODE_W-1:0]      code_d;
  vdacr_pkg::vdacr_mode_e mode_q;
  vdacr_pkg::vdacr_mode_e mode_d;
  logic                   sync_q;
  logic                   sync_d;
  logic                   blank_q;
  logic                   blank_d;
  logic                   setup_q;
  logic                   setup_d;
  logic [1:0]             ctrl_q;
  logic [1:0]             ctrl_d;
  logic                   confl_q;
  logic                   confl_d;
  logic [31:0]            count_q;
  logic [31:0]            count_d;
  logic                   apb_acc;
  logic                   apb_wr;
  logic                   pready_q;
  logic                   pready_d;
  logic                   pslverr_q;
  logic                   pslverr_d;
  logic [31:0]            prdata_q;
  logic [31:0]            prdata_d;
  logic [31:0]            status;

  ////////////////////////////////////////////////////////////////////////////
  // pixel fifo

  vdacr_fifo #(
    .WIDTH (CODE_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .pclk     (pclk),
    .presetn  (presetn),
    .flush    (flush),
    .in_valid (push),
    .in_data  (pix_code),
    .in_ready (fifo_in_ready),
    .out      (pix_s)
  );

  assign flush  = ctrl_q[vdacr_pkg::CTRL_FLUSH_BIT];
  assign enable = ctrl_q[vdacr_pkg::CTRL_EN_BIT];
  // ready is registered, so it is promised one slot ahead
  assign push   = pix_valid && pix_ready_q;

  // own fill count: pix_ready must come from a flop, not from the fifo
  always_comb begin
    fill_d = fill_q;
    if (flush) begin
      fill_d = '0;
    end else if (push && !pop) begin
      fill_d = fill_q + FW'(1);
    end else if (pop && !push) begin
      fill_d = fill_q - FW'(1);
    end
    // one slot spare: a push may land in the cycle ready is dropped
    pix_ready_d = (fill_d <= FW'(DEPTH - 2));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_q      <= '0;
      pix_ready_q <= 1'b0;
      strobe_q    <= 1'b0;
    end else begin
      fill_q      <= fill_d;
      pix_ready_q <= pix_ready_d;
      strobe_q    <= strobe;
    end
  end

  AST_NO_OVERFLOW: assert property (@(posedge pclk) disable iff (!presetn)
    push |-> fifo_in_ready)
    else $error("pixel accepted while the fifo was full");

  ////////////////////////////////////////////////////////////////////////////
  // strobe and overrides

  // idle strobe is low, so strobe_q resets low: no false edge after reset
  assign strobe_rise = strobe && !strobe_q;
  // a strobe consumes its slot while enabled and not flushing, even when an override discards it
  assign pix_s.ready = strobe_rise && enable && !flush;
  assign pop         = pix_s.valid && pix_s.ready;
  assign clearing    = !sync_n || !blank_n;
  assign peak_on     = !peak_n;
  // clearing wins at the input register when the driver breaks the rule; peak still drops the setup switch
  assign conflict    = clearing && peak_on;
  assign load        = pop && !clearing && !peak_on;

  ////////////////////////////////////////////////////////////////////////////
  // input register, one slice per bit

  for (genvar b = 0; b < CODE_W; b++) begin : g_code_bit
    assign code_d[b] = clearing ? 1'b0 :
                       peak_on  ? 1'b1 :
                       load     ? pix_s.data[b] :
                       code_q[b];
  end

  ////////////////////////////////////////////////////////////////////////////
  // current switches and mode tracker

  always_comb begin
    sync_d  = !sync_n;
    blank_d = !blank_n;
    setup_d = peak_n;
    mode_d  = mode_q;
    if (clearing || peak_on) begin
      mode_d = vdacr_pkg::VDACR_ST_FORCED;
    end else begin
      unique case (mode_q)
        vdacr_pkg::VDACR_ST_PIXEL: begin
          mode_d = vdacr_pkg::VDACR_ST_PIXEL;
        end
        vdacr_pkg::VDACR_ST_FORCED: begin
          // peak leaves its ones behind; sync and blank leave black
          if (load || code_q != vdacr_pkg::CODE_BLACK) begin
            mode_d = vdacr_pkg::VDACR_ST_PIXEL;
          end else begin
            mode_d = vdacr_pkg::VDACR_ST_BLACK;
          end
        end
        vdacr_pkg::VDACR_ST_BLACK: begin
          if (load) begin
            mode_d = vdacr_pkg::VDACR_ST_PIXEL;
          end
        end
        default: begin
          mode_d = vdacr_pkg::VDACR_ST_BLACK;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_q  <= CODE_W'(vdacr_pkg::CODE_RESET);
      mode_q  <= vdacr_pkg::VDACR_ST_BLACK;
      sync_q  <= 1'b0;
      blank_q <= 1'b0;
      setup_q <= 1'b1;
    end else begin
      code_q  <= code_d;
      mode_q  <= mode_d;
      sync_q  <= sync_d;
      blank_q <= blank_d;
      setup_q <= setup_d;
    end
  end

  // code goes straight to the gray-scale switches, levels are analog
  assign dac_code    = code_q;
  assign sw_sync_on  = sync_q;
  assign sw_blank_on = blank_q;
  assign sw_setup_on = setup_q;
  assign pix_ready   = pix_ready_q;

  AST_SYNC_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    !sync_n |=> (dac_code == vdacr_pkg::CODE_BLACK) && sw_sync_on)
    else $error("sync did not clear the input register");

  AST_BLANK_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    !blank_n |=> (dac_code == vdacr_pkg::CODE_BLACK) && sw_blank_on)
    else $error("blanking did not clear the input register");

  AST_PEAK_SETS: assert property (@(posedge pclk) disable iff (!presetn)
    (peak_on && !clearing) |=> (dac_code == vdacr_pkg::CODE_WHITE) && !sw_setup_on)
    else $error("peak white did not set the register or drop setup");

  AST_HELD_UNDER_SYNC: assert property (@(posedge pclk) disable iff (!presetn)
    (clearing && strobe_rise) |=> dac_code == vdacr_pkg::CODE_BLACK)
    else $error("strobe loaded a code under sync or blanking");

  AST_SWITCH_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> (sw_sync_on == !$past(sync_n)) && (sw_blank_on == !$past(blank_n)))
    else $error("sync or blank switch lags its control");

  AST_BLACK_UNTIL_STROBE: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == vdacr_pkg::VDACR_ST_BLACK) |-> dac_code == vdacr_pkg::CODE_BLACK)
    else $error("output left black without a strobe");

  AST_LOAD_TAKES_HEAD: assert property (@(posedge pclk) disable iff (!presetn)
    load |=> dac_code == $past(pix_s.data))
    else $error("strobe did not capture the head pixel");

  AST_HOLD_NO_EVENT: assert property (@(posedge pclk) disable iff (!presetn)
    (!load && !clearing && !peak_on) |=> $stable(dac_code))
    else $error("code changed without strobe or control");

  ////////////////////////////////////////////////////////////////////////////
  // register bus: one wait state, answer registered

  assign apb_acc = psel && penable;
  assign apb_wr  = apb_acc && pready_q && pwrite;

  always_comb begin
    status                               = '0;
    status[vdacr_pkg::ST_SYNC_BIT]       = sync_q;
    status[vdacr_pkg::ST_BLANK_BIT]      = blank_q;
    status[vdacr_pkg::ST_PEAK_BIT]       = !setup_q;
    status[vdacr_pkg::ST_CONFL_BIT]      = confl_q;
    status[vdacr_pkg::ST_EMPTY_BIT]      = !pix_s.valid;
    status[vdacr_pkg::ST_FULL_BIT]       = !fifo_in_ready;
  end

  always_comb begin
    ctrl_d                           = ctrl_q;
    // flush is a one-cycle pulse, never left standing
    ctrl_d[vdacr_pkg::CTRL_FLUSH_BIT] = 1'b0;
    confl_d                          = confl_q;
    count_d                          = count_q;
    pready_d                         = apb_acc && !pready_q;
    pslverr_d                        = 1'b0;
    prdata_d                         = prdata_q;
    if (load) begin
      count_d = count_q + 32'h1;
    end
    if (apb_wr && paddr == vdacr_pkg::ADDR_CTRL) begin
      ctrl_d = pwdata[1:0];
    end
    if (apb_wr && paddr == vdacr_pkg::ADDR_STATUS && pwdata[vdacr_pkg::ST_CONFL_BIT]) begin
      confl_d = 1'b0;
    end
    // set after clear: an event in the clearing cycle is not lost
    if (conflict) begin
      confl_d = 1'b1;
    end
    // read data is formed in the first access cycle, shown in the second
    if (apb_acc && !pready_q) begin
      prdata_d = '0;
      case (paddr)
        vdacr_pkg::ADDR_CTRL: begin
          prdata_d = {30'h0, ctrl_q};
        end
        vdacr_pkg::ADDR_STATUS: begin
          prdata_d = status;
        end
        vdacr_pkg::ADDR_CODE: begin
          prdata_d = {{(32 - CODE_W){1'b0}}, code_q};
        end
        vdacr_pkg::ADDR_COUNT: begin
          prdata_d = count_q;
        end
        default: begin
          pslverr_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= vdacr_pkg::CTRL_RESET;
      confl_q   <= 1'b0;
      count_q   <= 32'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      ctrl_q    <= ctrl_d;
      confl_q   <= confl_d;
      count_q   <= count_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign prdata  = prdata_q;
endmodule

// ===== design/vdacr_pkg.sv
/*
  Package for the video converter input register front end: code widths, code values,
  timing figures and the one-hot state codes of the override tracker.
  Assumes a 40 MHz pclk; nothing else.
*/
package vdacr_pkg;

  localparam int unsigned CODE_W       = 8;
  localparam logic [7:0]  CODE_BLACK   = 8'h00;
  localparam logic [7:0]  CODE_WHITE   = 8'hFF;
  localparam logic [7:0]  CODE_RESET   = 8'h00;

  // times in their own units
  localparam int unsigned CLK_MHZ        = 40;
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned MAX_UPDATE_MHZ = 40;
  localparam int unsigned SETTLE_NS      = 12;
  // longest time rounds down, but never under one cycle
  localparam int unsigned SETTLE_CYC_RAW = (SETTLE_NS * CLK_MHZ) / 1000;
  localparam int unsigned SETTLE_CYC     = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
  localparam int unsigned MIN_UPDATE_CYC_RAW = (CLK_MHZ + MAX_UPDATE_MHZ - 1) / MAX_UPDATE_MHZ;
  localparam int unsigned MIN_UPDATE_CYC =
      (MIN_UPDATE_CYC_RAW < 1) ? 1 : MIN_UPDATE_CYC_RAW;

  localparam int unsigned FIFO_DEPTH = 8;

  // APB map
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CODE   = 8'h08;
  localparam logic [7:0] ADDR_COUNT  = 8'h0C;
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_FLUSH_BIT = 1;
  localparam logic [1:0]  CTRL_RESET    = 2'h1;
  localparam int unsigned ST_SYNC_BIT   = 0;
  localparam int unsigned ST_BLANK_BIT  = 1;
  localparam int unsigned ST_PEAK_BIT   = 2;
  localparam int unsigned ST_CONFL_BIT  = 3;
  localparam int unsigned ST_EMPTY_BIT  = 4;
  localparam int unsigned ST_FULL_BIT   = 5;

  typedef enum logic [2:0] {
    VDACR_ST_PIXEL  = 3'b001,
    VDACR_ST_FORCED = 3'b010,
    VDACR_ST_BLACK  = 3'b100
  } vdacr_mode_e;

endpackage

// ===== design/vdacr_stream_if.sv
/*
  Valid/ready carrier between the pixel FIFO and the input register stage.
  Assumes both ends share pclk.
*/
`timescale 1ns/10ps
interface vdacr_stream_if #(
  parameter int unsigned W = 8
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input  ready);
  modport snk (input  valid, input  data, output ready);
endinterface

// ===== design/vdacr_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides, parameterised width and depth.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
module vdacr_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             flush,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  vdacr_stream_if.src           out
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
      $error("fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
  logic             push, pop, empty, full;

  assign empty     = (wr_q == rd_q);
  assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign in_ready  = !full;
  assign out.valid = !empty;
  assign out.data  = mem_q[rd_q[AW-1:0]];
  assign push      = in_valid && !full;
  assign pop       = out.valid && out.ready;

  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    if (flush) begin
      rd_d = wr_q;
    end else begin
      if (push) wr_d = wr_q + 1'b1;
      if (pop)  rd_d = rd_q + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // storage has no reset; emptiness is carried by the pointers
  always_ff @(posedge pclk) begin
    if (push && !flush) mem_q[wr_q[AW-1:0]] <= in_data;
  end
endmodule

// ===== verif/vdacr_src.sv
/*
  Pixel source model: hands codes to the FIFO by valid/ready, then strobes them in.
  Assumes it shares pclk with the block.
*/
`timescale 1ns/10ps
module vdacr_src (
  input  wire logic  pclk,
  input  wire logic  pix_ready,
  output logic [7:0] pix_code,
  output logic       pix_valid,
  output logic       strobe,
  output logic       stuck
);
  initial begin
    pix_code = 8'h00;
    pix_valid = 1'b0;
    strobe = 1'b0;
    stuck = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic send(input logic [7:0] c);
    int k;
    pix_code <= c;
    pix_valid <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge pclk);
      if (pix_ready === 1'b1) break;
    end
    if (k == 50) stuck <= 1'b1;
    pix_valid <= 1'b0;
    // released data shows the inverse, never the old code
    pix_code <= ~c;
    repeat (2) @(posedge pclk);
    strobe <= 1'b1;
    @(posedge pclk);
    strobe <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

// ===== verif/video_dac_input_register_control_test.sv
/*
  Self-checking bench: random and corner pixel codes, overrides, APB accesses.
  Assumes vdacr_top and the vdacr_src pixel source model.
*/
`timescale 1ns/10ps
module video_dac_input_register_control_test;
  logic pclk = 0, presetn = 0, sync_n = 1, blank_n = 1, peak_n = 1;
  logic psel = 0, penable = 0, pwrite = 0, pix_valid, pix_ready, strobe, stuck, pready, pslverr;
  logic sw_sync_on, sw_blank_on, sw_setup_on, err = 0;
  logic [7:0] paddr = 8'h00, pix_code, dac_code;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h0DB9;
  int bad_count = 0, tests_run = 0;
  always #12.5 pclk = ~pclk;
  vdacr_src u_src (.pclk(pclk), .pix_ready(pix_ready), .pix_code(pix_code),
    .pix_valid(pix_valid), .strobe(strobe), .stuck(stuck));
  vdacr_top dut (.pclk(pclk), .presetn(presetn), .pix_code(pix_code), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .strobe(strobe), .sync_n(sync_n), .blank_n(blank_n),
    .peak_n(peak_n), .dac_code(dac_code), .sw_sync_on(sw_sync_on),
    .sw_blank_on(sw_blank_on), .sw_setup_on(sw_setup_on), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // code stands from the strobe edge on; look at it mid-cycle
  task automatic waitcode(input logic [7:0] e);
    @(negedge pclk);
    check("dac_code", {24'h0, dac_code}, {24'h0, e});
    @(posedge pclk);
  endtask
  // called just after a rising edge; returns one idle edge after the answer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) bad_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] c;
    int b;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, vdacr_pkg::ADDR_CTRL, 32'h0);
    check("ctrl", {30'h0, rd[1:0]}, {30'h0, vdacr_pkg::CTRL_RESET});
    apb(1'b0, 8'h40, 32'h0);
    check("slverr", {31'h0, err}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      c = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : seed[7:0];
      u_src.send(c);
      waitcode(c);
    end
    apb(1'b0, vdacr_pkg::ADDR_COUNT, 32'h0);
    check("count", rd, 32'h8);
    peak_n <= 1'b0;
    repeat (2) @(negedge pclk);
    check("peak", {24'h0, dac_code}, 32'hFF);
    check("setup", {31'h0, sw_setup_on}, 32'h0);
    @(posedge pclk);
    apb(1'b0, vdacr_pkg::ADDR_CODE, 32'h0);
    check("code", rd, 32'hFF);
    // peak drops on the edge that raises sync, so the two never overlap
    peak_n <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      if (i == 0) sync_n <= 1'b0;
      else blank_n <= 1'b0;
      repeat (2) @(negedge pclk);
      check("clear", {24'h0, dac_code}, 32'h0);
      check("switch", {31'h0, i ? sw_blank_on : sw_sync_on}, 32'h1);
      @(posedge pclk);
      apb(1'b0, vdacr_pkg::ADDR_STATUS, 32'h0);
      b = i ? vdacr_pkg::ST_BLANK_BIT : vdacr_pkg::ST_SYNC_BIT;
      check("status", {31'h0, rd[b]}, 32'h1);
      u_src.send(8'h5A);
      @(negedge pclk);
      check("held", {24'h0, dac_code}, 32'h0);
      @(posedge pclk);
      sync_n <= 1'b1;
      blank_n <= 1'b1;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      check("black", {24'h0, dac_code}, 32'h0);
      check("released", {30'h0, sw_sync_on, sw_blank_on}, 32'h0);
      @(posedge pclk);
    end
    apb(1'b1, vdacr_pkg::ADDR_CTRL, 32'h0);
    u_src.send(8'h33);
    @(negedge pclk);
    check("disabled", {24'h0, dac_code}, 32'h0);
    @(posedge pclk);
    apb(1'b1, vdacr_pkg::ADDR_CTRL, 32'h3);
    apb(1'b0, vdacr_pkg::ADDR_STATUS, 32'h0);
    check("flushed", {31'h0, rd[vdacr_pkg::ST_EMPTY_BIT]}, 32'h1);
    apb(1'b0, vdacr_pkg::ADDR_CTRL, 32'h0);
    check("ctrl back", {30'h0, rd[1:0]}, {30'h0, vdacr_pkg::CTRL_RESET});
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      u_src.send(seed[7:0]);
      waitcode(seed[7:0]);
    end
    check("stuck", {31'h0, stuck}, 32'h0);
    results();
  end
endmodule
